// ==== core/ssiph_pkg.sv ====
/*
  Constants for the SSI position head output block: word layout, flag
  positions, fault patterns and timing counts.
  Assumes a 10 MHz system clock and a controller SSI clock of 100..1000 kHz.
*/
package ssiph_pkg;
  localparam int WORD_BITS = 25;
  localparam int POS_BITS = 19;
  localparam int ERRNUM_BITS = 3;
  localparam int LEAD_ZEROS = 2;
  localparam int CNT_W = 5;
  localparam logic [POS_BITS-1:0] POS_ALL_ONES = 19'h7ffff;
  localparam logic [POS_BITS-1:0] POS_ZERO = 19'h00000;
  localparam logic [LEAD_ZEROS-1:0] LEAD_PATTERN = 2'h0;
  localparam logic TRAIL_BIT = 1'b0;
  localparam int CLK_HZ = 10_000_000;
  // Idle (monoflop) time after the last clock edge, in microseconds
  localparam int IDLE_TIME_US = 30;
  localparam int IDLE_CYCLES = (IDLE_TIME_US * (CLK_HZ / 1_000_000) > 0) ?
                               IDLE_TIME_US * (CLK_HZ / 1_000_000) : 1;
  localparam int IDLE_W = 12;
  typedef enum logic [1:0] {SSIPH_IDLE, SSIPH_SHIFT, SSIPH_HOLD} ssiph_state_type;
endpackage

// ==== core/ssiph_word_if.sv ====
/*
  Carries the live SSI word from the system-clock side to the link side, and
  the frame-started level back.
  Assumes the word is steady around the first link clock edge of a frame.
*/
interface ssiph_word_if;
  logic [ssiph_pkg::WORD_BITS-1:0] word;
  logic frame_started;
  modport src (output word, input frame_started);
  modport dst (input word, output frame_started);
endinterface

// ==== core/ssiph_link.sv ====
/*
  Link-side shifter running on the controller SSI clock.
  Assumes the controller idles its clock high and that link_rst_b, from the
  system side, is only asserted and released while the clock stands high.
*/
module ssiph_link (
  // Link
  input wire logic ssi_clk,
  input wire logic link_rst_b,
  output logic ssi_data,
  // Word
  ssiph_word_if.dst wif
);
  logic [ssiph_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [ssiph_pkg::WORD_BITS-1:0] shift_reg, shift_next;
  logic started_reg, started_next;
  logic data_reg, data_next;

  always_comb begin
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    started_next = started_reg;
    data_next = data_reg;
    if (!started_reg) begin
      // First edge: freeze the word here; head status must be steady now
      started_next = 1'b1;
      shift_next = wif.word;
      data_next = 1'b0;
    end else if (cnt_reg < ssiph_pkg::CNT_W'(ssiph_pkg::WORD_BITS)) begin
      data_next = shift_reg[ssiph_pkg::WORD_BITS-1];
      shift_next = {shift_reg[ssiph_pkg::WORD_BITS-2:0], 1'b0};
      cnt_next = cnt_reg + ssiph_pkg::CNT_W'(1);
    end else begin
      data_next = 1'b0;
    end
  end

  always_ff @(posedge ssi_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      cnt_reg <= '0;
      shift_reg <= '0;
      started_reg <= 1'b0;
      data_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      started_reg <= started_next;
      data_reg <= data_next;
    end
  end

  assign ssi_data = data_reg;
  assign wif.frame_started = started_reg;
endmodule

// ==== core/ssiph_top.sv ====
/*
  SSI output logic of an absolute linear position head.
  Assumes position and status come from logic on sys_clk; the SSI clock
  comes from the controller and is unrelated to sys_clk.
*/
module ssiph_top #(
  parameter bit GRAY_CODE = 1'b0,
  parameter int IDLE_CYCLES = ssiph_pkg::IDLE_CYCLES
) (
  // System
  input wire logic sys_clk,
  input wire logic rst_b,
  // Head status
  input wire logic [ssiph_pkg::POS_BITS-1:0] position,
  input wire logic fault,
  input wire logic [ssiph_pkg::ERRNUM_BITS-1:0] error_number,
  input wire logic out_of_tolerance,
  input wire logic no_rail,
  input wire logic soiled,
  // SSI link
  input wire logic ssi_clk,
  output logic ssi_data,
  output logic frame_busy
);
  logic [1:0] rst_sync_reg;
  logic rst_i_b;
  logic [1:0] start_sync_reg;
  logic [1:0] clk_sync_reg;
  logic [ssiph_pkg::WORD_BITS-1:0] word_reg, word_next;
  logic active_reg, active_next;
  logic link_arm_reg, link_arm_next;
  logic [ssiph_pkg::IDLE_W-1:0] idle_reg, idle_next;
  ssiph_pkg::ssiph_state_type state_reg, state_next;
  logic [ssiph_pkg::POS_BITS-1:0] pos_bits;
  logic [ssiph_pkg::POS_BITS-1:0] pos_coded;
  logic err_f, rail_f, soil_f;
  logic start_seen, clk_seen;
  ssiph_word_if wif ();

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_i_b = rst_sync_reg[1];

  // Cross link signals into sys_clk
  always_ff @(posedge sys_clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      start_sync_reg <= 2'h0;
      clk_sync_reg <= 2'h3;
    end else begin
      start_sync_reg <= {start_sync_reg[0], wif.frame_started};
      clk_sync_reg <= {clk_sync_reg[0], ssi_clk};
    end
  end
  // Frame-started is a level: set by the first link edge, cleared by link_arm_reg
  assign start_seen = start_sync_reg[1];
  assign clk_seen = ~clk_sync_reg[1];

  // Fault patterns and coding
  always_comb begin
    err_f = 1'b0;
    rail_f = 1'b0;
    soil_f = soiled;
    pos_bits = position;
    if (fault) begin
      err_f = 1'b1;
      pos_bits = ssiph_pkg::POS_ZERO;
      pos_bits[ssiph_pkg::ERRNUM_BITS-1:0] = error_number;
    end else if (no_rail) begin
      rail_f = 1'b1;
      pos_bits = ssiph_pkg::POS_ALL_ONES;
    end else if (out_of_tolerance) begin
      pos_bits = ssiph_pkg::POS_ALL_ONES;
    end
  end

  generate
    for (genvar i = 0; i < ssiph_pkg::POS_BITS; i++) begin : g_code
      if (i == ssiph_pkg::POS_BITS - 1) begin : g_msb
        assign pos_coded[i] = pos_bits[i];
      end else begin : g_rest
        assign pos_coded[i] = GRAY_CODE ? (pos_bits[i] ^ pos_bits[i+1]) : pos_bits[i];
      end
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    word_next = word_reg;
    active_next = active_reg;
    idle_next = idle_reg;
    case (state_reg)
      ssiph_pkg::SSIPH_IDLE: begin
        // Track live value so the word is ready at the first edge
        word_next = {ssiph_pkg::LEAD_PATTERN, pos_coded, rail_f, soil_f, err_f,
                     ssiph_pkg::TRAIL_BIT};
        if (start_seen) begin
          active_next = 1'b1;
          state_next = ssiph_pkg::SSIPH_SHIFT;
          idle_next = '0;
        end
      end
      ssiph_pkg::SSIPH_SHIFT: begin
        if (clk_seen) idle_next = '0;
        else idle_next = idle_reg + 1'b1;
        if (int'(idle_reg) >= IDLE_CYCLES - 1) begin
          active_next = 1'b0;
          state_next = ssiph_pkg::SSIPH_HOLD;
        end
      end
      ssiph_pkg::SSIPH_HOLD: begin
        if (!start_seen) state_next = ssiph_pkg::SSIPH_IDLE;
      end
      default: state_next = ssiph_pkg::SSIPH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      state_reg <= ssiph_pkg::SSIPH_IDLE;
      word_reg <= '0;
      active_reg <= 1'b0;
      idle_reg <= '0;
    end else begin
      state_reg <= state_next;
      word_reg <= word_next;
      active_reg <= active_next;
      idle_reg <= idle_next;
    end
  end

  // Link side is held cleared from the idle timeout until the started level
  // has been seen low; the link clock stands high all that time, so neither
  // assertion nor release of that reset meets a link clock edge.
  // A controller that clocks again inside the idle time is not answered.
  always_comb begin
    link_arm_next = 1'b1;
    if (state_next == ssiph_pkg::SSIPH_HOLD) link_arm_next = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_i_b) begin
    if (!rst_i_b) link_arm_reg <= 1'b0;
    else link_arm_reg <= link_arm_next;
  end

  assign wif.word = word_reg;

  // Serial shifter on the controller clock
  ssiph_link link_u (
    .ssi_clk(ssi_clk),
    .link_rst_b(link_arm_reg),
    .ssi_data(ssi_data),
    .wif(wif)
  );

  // Busy flag from a flop, high from frame start to idle timeout
  always_ff @(posedge sys_clk or negedge rst_i_b) begin
    if (!rst_i_b) frame_busy <= 1'b0;
    else frame_busy <= active_next;
  end
endmodule

// ==== testbench/ssiph_top_asserts.sv ====
/* Checker for ssiph_top: SSI word layout and frame hold.
   Assumes head inputs stay still while a frame runs. */
module ssiph_chk #(
  parameter bit GRAY_CODE = 1'b0,
  parameter int IDLE_CYCLES = 20
) (
  // System
  input wire logic sys_clk,
  input wire logic rst_b,
  // Head status
  input wire logic [18:0] position,
  input wire logic fault,
  input wire logic [2:0] error_number,
  input wire logic out_of_tolerance,
  input wire logic no_rail,
  input wire logic soiled,
  // Link
  input wire logic ssi_clk,
  input wire logic ssi_data,
  input wire logic frame_busy
);
  logic [4:0] n_reg;
  logic busy_q_reg;
  logic clr;
  logic [18:0] raw;
  logic [18:0] pos;
  always_comb begin
    raw = fault ? {16'h0000, error_number} : (no_rail | out_of_tolerance) ? 19'h7ffff : position;
    pos = GRAY_CODE ? raw ^ (raw >> 1) : raw;
  end
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) busy_q_reg <= 1'b0;
    else busy_q_reg <= frame_busy;
  // Edge count restarts once the frame is released
  assign clr = !rst_b | (busy_q_reg & !frame_busy);
  always_ff @(posedge ssi_clk or posedge clr)
    if (clr) n_reg <= 5'h00;
    else if (n_reg != 5'h1f) n_reg <= n_reg + 5'h01;
  property p_idle;
    @(posedge ssi_clk) disable iff (!rst_b) n_reg == 5'h00 |-> ssi_data;
  endproperty
  a_idle: assert property (p_idle) else $error("data not idle");
  property p_lead;
    @(posedge ssi_clk) disable iff (!rst_b) n_reg inside {5'h02, 5'h03} |-> !ssi_data;
  endproperty
  a_lead: assert property (p_lead) else $error("lead bit");
  property p_pos;
    @(posedge ssi_clk) disable iff (!rst_b)
      n_reg inside {[5'h04:5'h16]} |-> ssi_data == pos[5'h16 - n_reg];
  endproperty
  a_pos: assert property (p_pos) else $error("position bit");
  property p_rail;
    @(posedge ssi_clk) disable iff (!rst_b) n_reg == 5'h17 |-> ssi_data == (!fault & no_rail);
  endproperty
  a_rail: assert property (p_rail) else $error("no-rail bit");
  property p_soil;
    @(posedge ssi_clk) disable iff (!rst_b) n_reg == 5'h18 |-> ssi_data == soiled;
  endproperty
  a_soil: assert property (p_soil) else $error("soiling bit");
  property p_err;
    @(posedge ssi_clk) disable iff (!rst_b) n_reg == 5'h19 |-> ssi_data == fault;
  endproperty
  a_err: assert property (p_err) else $error("error bit");
  property p_trail;
    @(posedge ssi_clk) disable iff (!rst_b) n_reg == 5'h1a |-> !ssi_data;
  endproperty
  a_trail: assert property (p_trail) else $error("trail bit");
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_b) $rose(frame_busy) |=> frame_busy [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("frame released early");
  property p_end;
    @(posedge sys_clk) disable iff (!rst_b) $rose(frame_busy) |-> ##[1:60] !frame_busy;
  endproperty
  a_end: assert property (p_end) else $error("frame never released");
  // Cycles spent busy in the current frame
  logic [11:0] busy_cnt_reg;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) busy_cnt_reg <= 12'h000;
    else if (!frame_busy) busy_cnt_reg <= 12'h000;
    else if (busy_cnt_reg != 12'hfff) busy_cnt_reg <= busy_cnt_reg + 12'h001;
  property p_min;
    @(posedge sys_clk) disable iff (!rst_b)
      $fell(frame_busy) |-> int'(busy_cnt_reg) >= IDLE_CYCLES;
  endproperty
  a_min: assert property (p_min) else $error("idle time cut short");
endmodule

bind ssiph_top ssiph_chk #(.GRAY_CODE(GRAY_CODE), .IDLE_CYCLES(IDLE_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .position(position), .fault(fault),
  .error_number(error_number), .out_of_tolerance(out_of_tolerance),
  .no_rail(no_rail), .soiled(soiled), .ssi_clk(ssi_clk), .ssi_data(ssi_data),
  .frame_busy(frame_busy));

// ==== testbench/ssiph_ctrl_model.sv ====
/* Controller SSI input channel: bursts the link clock, captures two words.
   Assumes heads hold each bit from one rising edge to the next. */
module ssiph_ctrl_model (
  // Link
  output logic ssi_clk,
  input wire logic [1:0] ssi_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial ssi_clk = 1'b1;
  // Clock stands high outside frames; data read on the falling edge
  task automatic read_word(output logic [24:0] w0, output logic [24:0] w1);
    w0 = '0;
    w1 = '0;
    for (int i = 1; i <= 27; i++) begin
      #6 ssi_clk = 1'b0;
      if (i > 2) begin
        w0 = {w0[23:0], ssi_data[0]};
        w1 = {w1[23:0], ssi_data[1]};
      end
      #6 ssi_clk = 1'b1;
    end
  endtask
endmodule

// ==== testbench/ssi_position_head_output_test.sv ====
/* Bench for ssiph_top: Gray and binary heads read by one controller model.
   Assumes the idle time is shortened to 20 sys_clk cycles. */
module ssi_position_head_output_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [18:0] position = 19'h00000;
  logic fault = 1'b0;
  logic [2:0] error_number = 3'h0;
  logic out_of_tolerance = 1'b0;
  logic no_rail = 1'b0;
  logic soiled = 1'b0;
  logic ssi_clk;
  wire logic [1:0] ssi_data;
  wire logic [1:0] busy;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  ssiph_top #(.GRAY_CODE(1'b1), .IDLE_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .position(position), .fault(fault), .error_number(error_number),
    .out_of_tolerance(out_of_tolerance), .no_rail(no_rail), .soiled(soiled),
    .ssi_clk(ssi_clk), .ssi_data(ssi_data[0]), .frame_busy(busy[0]));
  ssiph_top #(.GRAY_CODE(1'b0), .IDLE_CYCLES(20)) dut_bin (.sys_clk(sys_clk), .rst_b(rst_b),
    .position(position), .fault(fault), .error_number(error_number),
    .out_of_tolerance(out_of_tolerance), .no_rail(no_rail), .soiled(soiled),
    .ssi_clk(ssi_clk), .ssi_data(ssi_data[1]), .frame_busy(busy[1]));
  ssiph_ctrl_model ctrl_u (.ssi_clk(ssi_clk), .ssi_data(ssi_data));
  function automatic logic [24:0] expect_word(input bit gray);
    logic [18:0] p;
    p = fault ? {16'h0000, error_number} : (no_rail | out_of_tolerance) ? 19'h7ffff : position;
    if (gray) p = p ^ (p >> 1);
    return {2'h0, p, !fault & no_rail, soiled, fault, 1'b0};
  endfunction
  task automatic frame(input string what);
    logic [24:0] wg;
    logic [24:0] wb;
    repeat (3) @(posedge sys_clk);
    ctrl_u.read_word(wg, wb);
    @(posedge sys_clk);
    #1;
    comparisons += 3;
    if (wg !== expect_word(1'b1)) begin
      errors++;
      $display("BAD %s gray expected %h seen %h", what, expect_word(1'b1), wg);
    end
    if (wb !== expect_word(1'b0)) begin
      errors++;
      $display("BAD %s binary expected %h seen %h", what, expect_word(1'b0), wb);
    end
    if (busy !== 2'h3) begin
      errors++;
      $display("BAD %s busy expected 3 seen %h", what, busy);
    end
    repeat (40) @(posedge sys_clk);
    $display("done %s", what);
  endtask
  task automatic t_plain;
    @(posedge sys_clk);
    position <= 19'h4d2b7;
    frame("plain");
  endtask
  task automatic t_fault;
    @(posedge sys_clk);
    fault <= 1'b1;
    error_number <= 3'h5;
    no_rail <= 1'b1;
    frame("fault");
  endtask
  task automatic t_oot;
    @(posedge sys_clk);
    fault <= 1'b0;
    no_rail <= 1'b0;
    out_of_tolerance <= 1'b1;
    frame("tolerance");
  endtask
  task automatic t_norail;
    @(posedge sys_clk);
    no_rail <= 1'b1;
    frame("no rail");
  endtask
  task automatic t_soil;
    @(posedge sys_clk);
    no_rail <= 1'b0;
    out_of_tolerance <= 1'b0;
    soiled <= 1'b1;
    frame("soiled");
    soiled <= 1'b0;
    frame("cleaned");
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_plain();
    t_fault();
    t_oot();
    t_norail();
    t_soil();
    finish_test();
  end
endmodule
